// file: logic/mq_flag_core.sv
// Flag boundary logic for a four-queue FIFO with common write and read ports.
// Assumes write and read strobes synchronous to core_clk_in and an APB master.
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`default_nettype none
// How it works
// - Packet mode 36/36: output-valid goes low one clock after write to empty queue.
// - Packet mode 36/36: missed write-to-read skew adds one further clock before output-valid low.
// - 36/36 both ports on queue: almost-full low after D+1-m writes.
// - 36 in, write-only or narrow output: almost-full low after D-m writes.
// - 18 in, 36 out: almost-full after 2*(D+1-m) writes; 9 in: four times.
// - 36/36 both ports on queue: full low after D+1 writes.
// - 36 in, write-only or narrow output: full low after D writes.
// - Narrow input, both ports, 36 out: full after (D+1) times two or four writes.
// - Narrow input, write only: full after D times two or four writes.
// - Full goes low on the very edge of the filling write.
// - Full releases after a read; missed skew adds one clock.
// - Almost-full flag goes low two clocks after boundary write.
// - Almost-full releases one clock after read, two if skew missed.
// - Almost-full bus bits: low after two clocks, high after one or two.
// - Write-port queue switch may delay a bus bit change up to two clocks.
// - 36/36 both ports: almost-empty high after n+2 writes.
// - 36 in, narrow output: almost-empty high after n+1 writes.
// - Default almost-full offset 8 or 128 from select at reset.
// - Default almost-empty offset 8 or 128 from select at reset.
// - Almost-empty goes low two clocks after the crossing read.
module mq_flag_core #(
  parameter int NQ = mq_flag_pkg::NUM_QUEUES
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic default_offset_select_in,
  input wire mq_flag_pkg::port_ops_t ops_in,
  input wire mq_flag_pkg::apb_req_t apb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic queue_full_flag_out,
  output logic almost_full_flag_out,
  output logic [NQ-1:0] almost_full_bus_out,
  output logic almost_empty_flag_out,
  output logic output_valid_flag_out
);
  import mq_flag_pkg::*;

  if (NQ != NUM_QUEUES)
  begin : g_bad_nq
    $error("NQ must equal four");
  end

  typedef logic [CNT_W-1:0] cnt_t;

  logic [31:0] config_reg;
  cnt_t depth;
  cnt_t af_offset;
  cnt_t ae_offset;
  cnt_t level [NQ];
  logic same_on_first [NQ];
  logic af_int [NQ];
  logic af_pipe;
  logic [NQ-1:0] bus_pipe;
  logic ae_pipe;
  logic [1:0] ov_pend;
  logic switch_d;
  logic [QSEL_W-1:0] wr_q_d;
  logic rst_seen;

  wire bus_width_t in_w = bus_width_t'(config_reg[CFG_IN_LSB +: 2]);
  wire bus_width_t out_w = bus_width_t'(config_reg[CFG_OUT_LSB +: 2]);
  wire packet_mode = config_reg[CFG_PACKET_BIT];
  wire skew_missed = config_reg[CFG_SKEW_BIT];
  wire wide_both = (in_w == WIDTH_36) && (out_w == WIDTH_36);

  // Scale a word count into writes for the input width
  function automatic cnt_t scale_in(input cnt_t v, input bus_width_t w);
    unique case (w)
      WIDTH_18: scale_in = cnt_t'(v << 1);
      WIDTH_9: scale_in = cnt_t'(v << 2);
      default: scale_in = v;
    endcase
  endfunction : scale_in

  // Boundary threshold with the extra stage when both ports share the queue and the output is 36 wide
  function automatic cnt_t limit(input cnt_t base, input logic both, input bus_width_t iw,
                                 input bus_width_t ow);
    cnt_t b;
    b = (both && ow == WIDTH_36) ? cnt_t'(base + 18'h00001) : base;
    limit = (iw == WIDTH_36) ? b : scale_in(b, iw);
  endfunction : limit

  wire [QSEL_W-1:0] wq = ops_in.wr_q;
  wire [QSEL_W-1:0] rq = ops_in.rd_q;

  wire cnt_t full_lim = limit(depth, same_on_first[wq], in_w, out_w);
  // Narrow input counts the extra stage for almost-full whenever the output is 36 wide
  wire cnt_t af_lim = limit(cnt_t'(depth - af_offset), same_on_first[wq] || in_w != WIDTH_36,
                            in_w, out_w);
  // Writes are refused while the write queue sits at its full boundary
  wire full_now = (level[wq] >= full_lim);
  wire af_hit = (level[wq] >= af_lim);
  wire do_wr = clk_en_in && ops_in.wr_en && !full_now;
  wire do_rd = clk_en_in && ops_in.rd_en && (level[rq] != '0);
  wire cnt_t ae_lim = (in_w == WIDTH_36 && out_w != WIDTH_36) ?
                      cnt_t'(ae_offset + 18'h00001) :
                      scale_in(cnt_t'(ae_offset + 18'h00002), in_w);
  wire cnt_t level_w_next = cnt_t'(level[wq] + (do_wr ? 18'h00001 : 18'h00000)
                                   - ((do_rd && rq == wq) ? 18'h00001 : 18'h00000));

  // full on the filling edge: compare of the level after this edge
  wire full_next = (level_w_next >= full_lim);

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < NQ; i++)
      begin
        level[i] <= '0;
        same_on_first[i] <= 1'b0;
      end
    end
    else if (clk_en_in)
    begin
      for (int i = 0; i < NQ; i++)
      begin
        if (level[i] == '0 && do_wr && wq == QSEL_W'(i))
          same_on_first[i] <= (rq == QSEL_W'(i));
        level[i] <= cnt_t'(level[i] + ((do_wr && wq == QSEL_W'(i)) ? 18'h00001 : 18'h00000)
                    - ((do_rd && rq == QSEL_W'(i)) ? 18'h00001 : 18'h00000));
      end
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      rst_seen <= 1'b0;
      af_offset <= OFFSET_SMALL;
      ae_offset <= OFFSET_SMALL;
      depth <= DEPTH_RESET;
      config_reg <= CONFIG_RESET;
    end
    else if (clk_en_in)
    begin
      // default offsets caught at reset release
      if (!rst_seen)
      begin
        rst_seen <= 1'b1;
        af_offset <= default_offset_select_in ? OFFSET_LARGE : OFFSET_SMALL;
        ae_offset <= default_offset_select_in ? OFFSET_LARGE : OFFSET_SMALL;
      end
      else if (apb_in.psel && apb_in.penable && apb_in.pwrite && pready_out)
      begin
        unique case (apb_in.paddr)
          ADDR_CONFIG: config_reg <= {26'h0000000, apb_in.pwdata[5:0]};
          ADDR_DEPTH: depth <= apb_in.pwdata[CNT_W-1:0];
          ADDR_AF_OFFSET: af_offset <= apb_in.pwdata[CNT_W-1:0];
          ADDR_AE_OFFSET: ae_offset <= apb_in.pwdata[CNT_W-1:0];
          default: ;
        endcase
      end
    end
  end

  wire mapped = (apb_in.paddr <= ADDR_WCOUNT) && (apb_in.paddr[1:0] == 2'h0);
  wire [31:0] status_word = {24'h000000, output_valid_flag_out, almost_empty_flag_out,
                             almost_full_flag_out, queue_full_flag_out, almost_full_bus_out};
  wire [31:0] rd_mux = (apb_in.paddr == ADDR_CONFIG) ? config_reg :
                       (apb_in.paddr == ADDR_DEPTH) ? {14'h0000, depth} :
                       (apb_in.paddr == ADDR_AF_OFFSET) ? {14'h0000, af_offset} :
                       (apb_in.paddr == ADDR_AE_OFFSET) ? {14'h0000, ae_offset} :
                       (apb_in.paddr == ADDR_STATUS) ? status_word :
                       (apb_in.paddr == ADDR_WCOUNT) ? {14'h0000, level[wq]} : 32'h00000000;

  // APB answers one cycle into the access phase
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      pready_out <= 1'b0;
      prdata_out <= 32'h00000000;
      pslverr_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      pready_out <= apb_in.psel && apb_in.penable && !pready_out;
      prdata_out <= rd_mux;
      pslverr_out <= apb_in.psel && apb_in.penable && !pready_out && !mapped;
    end
  end

  // Per-queue almost-full status for the bus
  wire [NQ-1:0] af_state;
  for (genvar g = 0; g < NQ; g++)
  begin : g_af
    assign af_state[g] = (level[g] >= limit(cnt_t'(depth - af_offset),
                                              same_on_first[g] || in_w != WIDTH_36,
                                              in_w, out_w));
  end
  // Low after two stages, high at once or after one more stage on missed skew
  wire [NQ-1:0] next_bus = (almost_full_bus_out & ~(af_state & ~bus_pipe)) |
                           (~af_state & (skew_missed ? bus_pipe : {NQ{1'b1}}));

  wire rd_switch = (wq != wr_q_d);
  wire ae_now = (level[rq] >= ae_lim);

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      queue_full_flag_out <= 1'b1;
      af_pipe <= 1'b1;
      almost_full_flag_out <= 1'b1;
      bus_pipe <= '1;
      almost_full_bus_out <= '1;
      ae_pipe <= 1'b0;
      almost_empty_flag_out <= 1'b0;
      output_valid_flag_out <= 1'b1;
      ov_pend <= 2'h0;
      switch_d <= 1'b0;
      wr_q_d <= '0;
    end
    else if (clk_en_in)
    begin
      wr_q_d <= wq;
      switch_d <= rd_switch;
      // active-low full follows next level at once
      // Missed skew only delays the release, never the assert
      queue_full_flag_out <= !(full_next || (skew_missed && full_now));
      // two-stage assert, release after one or two clocks
      af_pipe <= !af_hit;
      if (af_hit && !af_pipe)
        almost_full_flag_out <= 1'b0;
      else if (!af_hit && (!skew_missed || af_pipe))
        almost_full_flag_out <= 1'b1;
      // bus bits follow the flag timing, held during a write switch
      bus_pipe <= ~af_state;
      if (!(rd_switch || switch_d))
        almost_full_bus_out <= next_bus;
      // almost-empty high one clock after boundary, low two after read
      ae_pipe <= ae_now;
      almost_empty_flag_out <= ae_now || ae_pipe;
      // output-valid low after write to empty read queue
      if (do_rd && level[rq] == 18'h00001 && !(do_wr && wq == rq))
      begin
        ov_pend <= 2'h0;
        output_valid_flag_out <= 1'b1;
      end
      // Packet mode counts one or two clocks before showing the word
      else if (packet_mode && wide_both && do_wr && wq == rq && level[rq] == '0)
        ov_pend <= skew_missed ? 2'h2 : 2'h1;
      else if (ov_pend == 2'h2)
        ov_pend <= 2'h1;
      else if (ov_pend == 2'h1)
      begin
        ov_pend <= 2'h0;
        output_valid_flag_out <= 1'b0;
      end
      else if (level[rq] != '0)
        output_valid_flag_out <= 1'b0;
    end
  end

  // Building blocks for the multi-step flag checks
  sequence s_af_hit;
    clk_en_in && af_hit;
  endsequence
  sequence s_af_clear;
    clk_en_in && !af_hit;
  endsequence
  sequence s_bus_hit;
    clk_en_in && af_state[0] && !rd_switch && !switch_d;
  endsequence
  sequence s_ov_first;
    clk_en_in && packet_mode && wide_both && do_wr && wq == rq && level[rq] == '0;
  endsequence
  sequence s_quiet_rd;
    clk_en_in && !do_rd;
  endsequence

  chk_af_assert_two: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_af_hit ##1 s_af_hit |=> !almost_full_flag_out)
    else $error("almost-full did not assert");
  chk_default_offset: assert property (@(posedge core_clk_in) disable iff (rst_in)
    $rose(rst_seen) |-> af_offset == ($past(default_offset_select_in) ? OFFSET_LARGE :
                                      OFFSET_SMALL)
    || !$past(clk_en_in))
    else $error("default offset wrong");
  chk_ae_offset: assert property (@(posedge core_clk_in) disable iff (rst_in)
    $rose(rst_seen) |-> ae_offset == af_offset)
    else $error("almost-empty default wrong");
  chk_ae_latency: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in ##1 clk_en_in |-> almost_empty_flag_out == ($past(ae_now, 1) || $past(ae_now, 2)))
    else $error("almost-empty latency");
  chk_full_edge: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && full_next |=> !queue_full_flag_out)
    else $error("full late");
  chk_no_overfill: assert property (@(posedge core_clk_in) disable iff (rst_in)
    level[wq] <= full_lim)
    else $error("queue overfilled");
  chk_apb_ready: assert property (@(posedge core_clk_in) disable iff (rst_in)
    pready_out && clk_en_in |=> !pready_out)
    else $error("pready stuck");
  chk_ov_release: assert property (@(posedge core_clk_in) disable iff (rst_in)
    level[rq] == '0 && clk_en_in ##1 level[rq] == '0 && clk_en_in |=> output_valid_flag_out)
    else $error("output valid while empty");

  chk_af_release_one: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_af_hit ##1 s_af_clear ##0 !skew_missed |=> almost_full_flag_out)
    else $error("almost-full release late");

  // missed skew holds one more clock
  chk_af_skew_hold: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_af_hit ##1 s_af_hit ##1 s_af_clear ##0 skew_missed |=> !almost_full_flag_out)
    else $error("almost-full released early");

  // missed skew releases on second clock
  chk_af_release_skew: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_af_clear ##1 s_af_clear ##0 skew_missed |=> almost_full_flag_out)
    else $error("almost-full skew release late");

  // bus bit assert after two clocks
  chk_bus_assert: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_bus_hit ##1 s_bus_hit |=> !almost_full_bus_out[0])
    else $error("bus bit did not assert");

  // bus bit release after one clock
  chk_bus_release: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && !af_state[0] && !skew_missed && !rd_switch && !switch_d
    |=> almost_full_bus_out[0])
    else $error("bus bit release late");

  chk_full_release: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && !full_next && !(skew_missed && full_now) |=> queue_full_flag_out)
    else $error("full release late");

  chk_full_skew_hold: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && skew_missed && full_now |=> !queue_full_flag_out)
    else $error("full released early");

  chk_ov_one: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_ov_first ##0 !skew_missed ##1 s_quiet_rd |=> !output_valid_flag_out)
    else $error("output valid late");

  chk_ov_two: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_ov_first ##0 skew_missed ##1 s_quiet_rd ##1 s_quiet_rd |=> !output_valid_flag_out)
    else $error("output valid late on skew");

  // almost-empty rises one clock after boundary
  chk_ae_rise: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && ae_now |=> almost_empty_flag_out)
    else $error("almost-empty rise late");

  // almost-empty holds one clock after crossing read
  chk_ae_fall_hold: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && ae_pipe && !ae_now |=> almost_empty_flag_out)
    else $error("almost-empty fell early");
endmodule : mq_flag_core
`default_nettype wire

// file: logic/mq_flag_pkg.sv
// Constants and carrier types for the multi-queue flag boundary block.
// Assumes one clock domain and an APB master for software access.
`default_nettype none
package mq_flag_pkg;
  localparam int NUM_QUEUES = 4;
  localparam int QSEL_W = 2;
  localparam int CNT_W = 18;
  // Offsets chosen by default programming
  localparam logic [CNT_W-1:0] OFFSET_SMALL = 18'h00008;
  localparam logic [CNT_W-1:0] OFFSET_LARGE = 18'h00080;
  localparam logic [CNT_W-1:0] DEPTH_RESET = 18'h01000;
  // Register byte addresses
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_DEPTH = 8'h04;
  localparam logic [7:0] ADDR_AF_OFFSET = 8'h08;
  localparam logic [7:0] ADDR_AE_OFFSET = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_WCOUNT = 8'h14;
  // Config field positions
  localparam int CFG_IN_LSB = 0;
  localparam int CFG_OUT_LSB = 2;
  localparam int CFG_PACKET_BIT = 4;
  localparam int CFG_SKEW_BIT = 5;
  localparam logic [31:0] CONFIG_RESET = 32'h00000000;
  // Latencies in clock cycles
  localparam int AF_SET_LAT = 2;
  localparam int AF_CLR_LAT = 1;
  localparam int AE_CLR_LAT = 2;
  localparam int OV_SET_LAT = 1;
  typedef enum logic [1:0] {
    WIDTH_36 = 2'h0,
    WIDTH_18 = 2'h1,
    WIDTH_9 = 2'h2
  } bus_width_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic wr_en;
    logic [QSEL_W-1:0] wr_q;
    logic rd_en;
    logic [QSEL_W-1:0] rd_q;
  } port_ops_t;
endpackage : mq_flag_pkg
`default_nettype wire

// file: test/port_side_model.sv
// Writer and reader logic that drives the common queue ports.
// Assumes bench requests change just after the rising edge.
`default_nettype none
module port_side_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_go_in,
  input wire logic stall_in,
  input wire logic rd_go_in,
  input wire logic [mq_flag_pkg::QSEL_W-1:0] rd_q_in,
  output var mq_flag_pkg::port_ops_t ops_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import mq_flag_pkg::*;
  // Registered so strobes never move near the sampling edge
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      ops_out <= '0;
    else
      ops_out <= '{wr_go_in & ~stall_in, 2'h0, rd_go_in, rd_q_in};
  end
endmodule : port_side_model
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the flag boundary block.
// Assumes the port model drives queue traffic and APB reaches registers.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import mq_flag_pkg::*;
  localparam int D = 16;
  logic clk = 0, rst = 1, df = 0, wgo = 0, rgo = 0, stall = 0;
  logic [1:0] rq = 2'h0;
  apb_req_t apb = '0;
  port_ops_t ops;
  logic [31:0] prdata, rd;
  logic pready, perr, full, af, ae, ov, er;
  logic [3:0] afb;
  int fail_count = 0, check_count = 0, seed = 30935, cyc = 0, wc = 0;
  int c, k, m, n, s, x, e, lat;
  int wch[8192];
  logic [3:0] flg[8192];
  int cfgs[11] = '{8'h40, 8'h00, 8'h44, 8'h08, 8'h48, 8'h41, 8'h01, 8'h42, 8'h02, 8'h50, 8'h70};
  mq_flag_core DUT (.core_clk_in(clk), .rst_in(rst), .clk_en_in(1'h1),
    .default_offset_select_in(df), .ops_in(ops), .apb_in(apb), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(perr), .queue_full_flag_out(full),
    .almost_full_flag_out(af), .almost_full_bus_out(afb),
    .almost_empty_flag_out(ae), .output_valid_flag_out(ov));
  port_side_model partner (.clk_in(clk), .rst_in(rst), .wr_go_in(wgo), .stall_in(stall),
    .rd_go_in(rgo), .rd_q_in(rq), .ops_out(ops));
  initial
  begin
    forever #10 clk = ~clk;
  end
  // History of accepted writes and sampled flags per edge
  always @(posedge clk)
  begin
    if (ops.wr_en === 1'h1 && full === 1'h1)
      wc = wc + 1;
    wch[cyc] = wc;
    flg[cyc] = {full, af, ae, ov};
    cyc = cyc + 1;
    if (cyc > 6000)
    begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic ok(input logic v, input string what);
    check_count++;
    if (v !== 1'h1)
    begin
      fail_count++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : ok
  task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    apb <= '{1'h1, 1'h0, wr, a, d};
    @(posedge clk);
    apb.penable <= 1'h1;
    do
      @(posedge clk);
    while (pready !== 1'h1);
    rd = prdata;
    er = perr;
    apb <= '0;
  endtask : apb_xfer
  task automatic do_reset(input logic sel);
    rst <= 1'h1;
    df <= sel;
    wgo <= 1'h0;
    rgo <= 1'h0;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    wc = 0;
  endtask : do_reset
  function automatic int first_at(input int from, input int b, input logic v);
    for (int i = from; i < cyc; i++)
      if (flg[i][b] === v)
        return i;
    return from;
  endfunction : first_at
  initial
  begin
    for (int i = 0; i < 2; i++)
    begin
      do_reset(i[0]);
      ok({full, af, afb, ae, ov} === 8'hfd, "reset flags");
      apb_xfer(1'h0, ADDR_AF_OFFSET, 32'h0);
      ok(rd[17:0] === (i ? OFFSET_LARGE : OFFSET_SMALL), "af default");
      apb_xfer(1'h0, ADDR_AE_OFFSET, 32'h0);
      ok(rd[17:0] === (i ? OFFSET_LARGE : OFFSET_SMALL), "ae default");
    end
    apb_xfer(1'h0, 8'h40, 32'h0);
    ok(er === 1'h1, "unmapped read");
    foreach (cfgs[i])
    begin
      c = cfgs[i];
      do_reset(1'h0);
      m = 1 + ($random(seed) & 3);
      n = $random(seed) & 3;
      apb_xfer(1'h1, ADDR_DEPTH, D);
      apb_xfer(1'h1, ADDR_AF_OFFSET, m);
      apb_xfer(1'h1, ADDR_AE_OFFSET, n);
      apb_xfer(1'h1, ADDR_CONFIG, {26'h0, c[5:0]});
      rq <= c[6] ? 2'h0 : 2'h1;
      @(posedge clk);
      s = cyc;
      wgo <= 1'h1;
      while (full !== 1'h0)
      begin
        @(posedge clk);
        stall <= 1'($random(seed) & 1);
      end
      repeat (6) @(posedge clk);
      wgo <= 1'h0;
      k = 1 << (c & 3);
      e = (D + (c[6] && c[3:2] == 2'h0)) * k;
      x = first_at(s, 3, 1'h0);
      ok(wch[x - 1] == e && wch[x - 2] == e - 1, "full count");
      e = (c & 3) ? (D + 1 - m) * k : D - m + (c == 8'h40 || c[4]);
      x = first_at(s, 2, 1'h0);
      ok(wch[x - 3] == e && wch[x - 4] == e - 1, "af count");
      ok(afb === 4'he, "af bus");
      if (c[6])
      begin
        e = (c & 3) ? (n + 2) * k : n + 1 + (c[3:2] == 2'h0);
        x = first_at(s, 1, 1'h1);
        ok(wch[x - 2] == e && wch[x - 3] == e - 1, "ae count");
      end
      if (c[4])
      begin
        lat = 1 + c[5];
        x = first_at(s, 0, 1'h0);
        ok(wch[x - 1 - lat] == 1 && wch[x - 2 - lat] == 0, "ov latency");
      end
      rq <= 2'h0;
      rgo <= 1'h1;
      // Enough reads to drop below the almost-full boundary
      repeat (m * k + 1) @(posedge clk);
      rgo <= 1'h0;
      repeat (5) @(posedge clk);
      ok(full === 1'h1 && af === 1'h1 && afb === 4'hf, "release");
    end
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
